// ==== hdl/ebl_top.v ====
// Break, run-mode and mailbox logic between supervisor and target
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/10ps
`include "ebl_consts.vh"
// Contract
// RL1 - Each address holds nine-bit word with flag
// RL2 - Flag latches break, halts target via step
// RL3 - Break can trigger every cycle or move
// RL4 - Eight-bit mailbox mappable to program or data
// RL5 - Mapped mailbox disables RAM, answers all addresses
// RL6 - Breaks work on fetch and data accesses; here only fetches and data reads check the flag, data writes never do
// RL7 - Any number of breakpoints may be armed
// RL8 - Free run never halts target
// RL9 - Single-step runs one instruction then halts
// RL10 - Break mode runs until break, then halts
// RL11 - Trace mode shows pc each instruction
// RL12 - Trace-on-flag shows pc only at flags
// RL13 - Non-break mode pulses trigger on flags; here only free run and every-cycle trace mode pulse it
// RL14 - Supervisor can stop target any mode
// RL15 - Program and data up to 4K each
// RL16 - Mailbox call opcode fetched exactly once
// RL17 - Data move writes mailbox then halts
// RL18 - Supervisor clears break before release
module ebl_top
(
    // Clock and reset
    input wire MCLK,
    input wire RST_B,
    // APB slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output wire [31:0] PRDATA,
    output wire PREADY,
    output wire PSLVERR,
    // Target bus
    input wire [11:0] T_ADDR,
    input wire T_PFETCH,
    input wire T_DRD,
    input wire T_DWR,
    input wire T_XMOVE,
    input wire T_CYCLE,
    input wire T_INSTR,
    input wire [7:0] T_WDATA,
    output wire [7:0] T_RDATA,
    output wire T_STEP_B,
    // Instruments, display and interrupt
    output wire TRIG_OUT,
    output wire TRACE_REQ,
    output wire IRQ
);
    // Bus qualifiers: access phase and writes within it
    wire acc_r_w = PSEL && PENABLE;
    wire wr_acc = acc_r_w && PWRITE;
    wire ctrl_wr = wr_acc && (PADDR == `EBL_OFF_CTRL);

    // Trigger length in cycles, sized to the pulse counter
    localparam [7:0] PULSE_LEN = `EBL_PULSE_CYC;

    // Run mode and mailbox mapping
    reg [2:0] mode_r;
    reg map_prog_r;
    reg map_data_r;
    // Space that the flag access port reaches, 1 is data
    reg bspace_r;

    // Break latch, halt and the one-shot step arm
    reg break_r;
    reg halt_r;
    reg step_cnt_r;

    // Mailbox byte shared by both processors
    reg [7:0] mbox_r;

    // Sticky events and their mask
    reg [`EBL_ST_W-1:0] stat_r;
    reg [`EBL_ST_W-1:0] imsk_r;

    // Flag access address and last instruction address
    reg [11:0] bp_addr_r;
    reg [11:0] trace_pc_r;

    // Trigger stretch counter and bus read data
    reg [7:0] pulse_cnt_r;
    reg [31:0] rdata_r;

    // Target read strobes, one cycle late to meet RAM data
    reg tp_fetch_r;
    reg td_rd_r;

    // Nine-bit words from both spaces, target and supervisor ports
    wire [8:0] p_word;
    wire [8:0] d_word;
    wire [8:0] p_sword;
    wire [8:0] d_sword;
    // Flag port reads back whichever space is selected
    wire [8:0] s_word = bspace_r ? d_sword : p_sword;
    wire s_mem_wr = wr_acc && (PADDR == `EBL_OFF_BPDT);

    // Program RAM with flags, held off while mailbox owns the space
    ebl_flag_mem u_prog
    (
        .clk(MCLK),
        .t_addr(T_ADDR),
        .t_en(T_PFETCH && !map_prog_r), // RL5
        .t_wr(1'b0),
        .t_wdata(T_WDATA),
        .t_rword(p_word),
        .s_en(!bspace_r),
        .s_wr(s_mem_wr),
        .s_addr(bp_addr_r),
        .s_wdata(PWDATA[8:0]),
        .s_rword(p_sword)
    );

    // Data RAM with flags
    ebl_flag_mem u_data
    (
        .clk(MCLK),
        .t_addr(T_ADDR),
        .t_en((T_DWR || T_DRD) && !map_data_r), // RL5
        .t_wr(T_DWR),
        .t_wdata(T_WDATA),
        .t_rword(d_word),
        .s_en(bspace_r),
        .s_wr(s_mem_wr),
        .s_addr(bp_addr_r),
        .s_wdata(PWDATA[8:0]),
        .s_rword(d_sword)
    );

    // Registered read strobes line up with synchronous RAM output
    always @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            tp_fetch_r <= 1'b0;
            td_rd_r <= 1'b0;
        end
        else
        begin
            tp_fetch_r <= T_PFETCH;
            td_rd_r <= T_DRD;
        end
    end

    // Flag seen on fetch or data read, unless mailbox answers
    wire flag_hit = (tp_fetch_r && !map_prog_r && p_word[8]) ||
                    (td_rd_r && !map_data_r && d_word[8]); // RL6

    // Mailbox answers any address when mapped; a fetch takes precedence
    // Address is ignored here on purpose, so any fetch lands on the mailbox
    reg [7:0] t_rdata_mux;
    always @*
    begin
        t_rdata_mux = d_word[7:0];
        if (tp_fetch_r && map_prog_r)
            t_rdata_mux = mbox_r; // RL4 RL5
        else if (tp_fetch_r)
            t_rdata_mux = p_word[7:0]; // RL1
        else if (td_rd_r && map_data_r)
            t_rdata_mux = mbox_r; // RL4 RL5
    end
    assign T_RDATA = t_rdata_mux;

    // Break request source chosen by run mode
    // Step arm keeps a second instruction from slipping past a step
    // Flag hits come a cycle after the strobe, in line with RAM data
    reg brk_set;
    always @*
    begin
        brk_set = 1'b0;
        case (mode_r)
            `EBL_MODE_FREE: brk_set = 1'b0; // RL8
            `EBL_MODE_STEP: brk_set = T_INSTR && step_cnt_r; // RL9
            `EBL_MODE_BREAK: brk_set = flag_hit; // RL10 RL2
            `EBL_MODE_TRACE: brk_set = T_CYCLE; // RL3 RL11
            `EBL_MODE_TFLAG: brk_set = flag_hit; // RL12
            `EBL_MODE_XMOVE: brk_set = T_XMOVE; // RL3 RL17
            default: brk_set = 1'b0;
        endcase
    end

    // Supervisor commands, each a one-cycle strobe on a control write
    wire stop_cmd = ctrl_wr && PWDATA[`EBL_CTL_STOP]; // RL14
    wire rel_cmd = ctrl_wr && PWDATA[`EBL_CTL_REL];
    wire clr_cmd = ctrl_wr && PWDATA[`EBL_CTL_CLRB];
    // Trigger pulse on flags in free run and every-cycle trace mode only, not in trace-on-flag
    wire nb_flag = flag_hit && (mode_r == `EBL_MODE_FREE ||
                                mode_r == `EBL_MODE_TRACE); // RL13

    // Break latch: set wins over clear; release only when latch is clear
    // Refusing release while latched stops a stale break slipping through
    // Supervisor must clear first, then release in a later write
    always @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            break_r <= 1'b0;
            halt_r <= 1'b1;
            step_cnt_r <= 1'b0;
        end
        else
        begin
            if (brk_set || stop_cmd)
                break_r <= 1'b1; // RL2 RL14
            else if (clr_cmd)
                break_r <= 1'b0; // RL18
            if (brk_set || stop_cmd)
                halt_r <= 1'b1; // RL2 RL14
            else if (rel_cmd && !break_r)
                halt_r <= 1'b0; // RL18
            // Step: one instruction after release, then halt
            if (rel_cmd)
                step_cnt_r <= 1'b1; // RL9 RL16
            else if (T_INSTR)
                step_cnt_r <= 1'b0;
        end
    end
    assign T_STEP_B = ~halt_r; // RL2

    // Trigger pulse stretched to instrument width
    always @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
            pulse_cnt_r <= 8'h00;
        else if (nb_flag)
            pulse_cnt_r <= PULSE_LEN; // RL13
        else if (pulse_cnt_r != 8'h00)
            pulse_cnt_r <= pulse_cnt_r - 8'h01;
    end
    assign TRIG_OUT = (pulse_cnt_r != 8'h00);

    // Display request for trace modes
    assign TRACE_REQ = halt_r && (mode_r == `EBL_MODE_TRACE ||
                                  mode_r == `EBL_MODE_TFLAG); // RL11 RL12

    // Mailbox, control and address registers
    always @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            mode_r <= `EBL_MODE_FREE;
            map_prog_r <= 1'b0;
            map_data_r <= 1'b0;
            bspace_r <= 1'b0;
            mbox_r <= 8'h00;
            bp_addr_r <= 12'h000;
            trace_pc_r <= 12'h000;
            imsk_r <= 4'h0;
        end
        else
        begin
            if (T_DWR && map_data_r)
                mbox_r <= T_WDATA; // RL17
            else if (wr_acc && PADDR == `EBL_OFF_MBOX)
                mbox_r <= PWDATA[7:0]; // RL4 RL16
            if (T_INSTR)
                trace_pc_r <= T_ADDR; // RL11
            if (wr_acc && PADDR == `EBL_OFF_CTRL)
            begin
                mode_r <= PWDATA[`EBL_CTL_MODE_HI:`EBL_CTL_MODE_LO];
                map_prog_r <= PWDATA[`EBL_CTL_MAPP]; // RL4
                map_data_r <= PWDATA[`EBL_CTL_MAPD]; // RL4
                bspace_r <= PWDATA[`EBL_CTL_BSPACE];
            end
            if (wr_acc && PADDR == `EBL_OFF_BPAD)
                bp_addr_r <= PWDATA[11:0]; // RL15
            if (wr_acc && PADDR == `EBL_OFF_IMSK)
                imsk_r <= PWDATA[3:0];
        end
    end

    // Sticky status events
    wire ev_halt = brk_set | stop_cmd;
    wire ev_flag = flag_hit;
    // Trace event marks a break taken in a trace mode only
    wire ev_trace = brk_set && (mode_r == `EBL_MODE_TRACE ||
                                mode_r == `EBL_MODE_TFLAG); // RL11 RL12
    // Target store into the mapped mailbox
    wire ev_mbox = T_DWR && map_data_r;
    wire [3:0] ev = {ev_mbox, ev_trace, ev_flag, ev_halt};

    // Sticky status, write one to clear, set wins
    // An event in the same cycle as its clear stays visible
    wire [3:0] w1c = (wr_acc && PADDR == `EBL_OFF_STAT) ? PWDATA[3:0] : 4'h0;
    genvar gi;
    generate
        for (gi = 0; gi < `EBL_ST_W; gi = gi + 1)
        begin : g_stat
            always @(posedge MCLK or negedge RST_B)
            begin
                if (!RST_B)
                    stat_r[gi] <= 1'b0;
                else if (ev[gi])
                    stat_r[gi] <= 1'b1;
                else if (w1c[gi])
                    stat_r[gi] <= 1'b0;
            end
        end
    endgenerate
    assign IRQ = |(stat_r & imsk_r);

    // APB read mux, registered in setup phase
    // Capturing at setup lets PREADY stay high with no wait states
    // Halt reads back at the stop bit position of the control word
    always @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
            rdata_r <= 32'h00000000;
        else if (PSEL && !PENABLE && !PWRITE)
        begin
            case (PADDR)
                `EBL_OFF_CTRL: rdata_r <= {23'h000000, bspace_r, 2'b00, halt_r, map_data_r,
                                           map_prog_r, mode_r};
                `EBL_OFF_STAT: rdata_r <= {27'h0000000, break_r, stat_r};
                `EBL_OFF_IMSK: rdata_r <= {28'h0000000, imsk_r};
                `EBL_OFF_MBOX: rdata_r <= {24'h000000, mbox_r};
                `EBL_OFF_BPAD: rdata_r <= {20'h00000, bp_addr_r};
                `EBL_OFF_BPDT: rdata_r <= {23'h000000, s_word};
                `EBL_OFF_TRPC: rdata_r <= {20'h00000, trace_pc_r};
                default: rdata_r <= 32'h00000000;
            endcase
        end
    end
    assign PRDATA = rdata_r;
    assign PREADY = 1'b1;
    assign PSLVERR = 1'b0;
endmodule

// ==== hdl/ebl_consts.vh ====
// Constants for the emulator break link logic
`ifndef EBL_CONSTS_VH
`define EBL_CONSTS_VH
// Register byte offsets
`define EBL_OFF_CTRL 12'h000
`define EBL_OFF_STAT 12'h004
`define EBL_OFF_IMSK 12'h008
`define EBL_OFF_MBOX 12'h00c
`define EBL_OFF_BPAD 12'h010
`define EBL_OFF_BPDT 12'h014
`define EBL_OFF_TRPC 12'h018
// Control fields
`define EBL_CTL_MODE_LO 0
`define EBL_CTL_MODE_HI 2
`define EBL_CTL_MAPP 3
`define EBL_CTL_MAPD 4
`define EBL_CTL_STOP 5
`define EBL_CTL_REL 6
`define EBL_CTL_CLRB 7
`define EBL_CTL_BSPACE 8
// Run modes
`define EBL_MODE_FREE 3'h0
`define EBL_MODE_STEP 3'h1
`define EBL_MODE_BREAK 3'h2
`define EBL_MODE_TRACE 3'h3
`define EBL_MODE_TFLAG 3'h4
`define EBL_MODE_XMOVE 3'h5
// Status bits
`define EBL_ST_HALT 0
`define EBL_ST_FLAG 1
`define EBL_ST_TRACE 2
`define EBL_ST_MBOXW 3
`define EBL_ST_W 4
// Memory geometry
`define EBL_AW 12
`define EBL_DEPTH 4096
`define EBL_WW 9
// Trigger pulse length in cycles
`define EBL_PULSE_NS 200
`define EBL_CLK_NS 40
`define EBL_PULSE_CYC ((`EBL_PULSE_NS + `EBL_CLK_NS - 1) / `EBL_CLK_NS)
`endif

// ==== hdl/ebl_flag_mem.v ====
// Nine-bit storage for one address space: byte plus break flag
`timescale 1ns/10ps
`include "ebl_consts.vh"
module ebl_flag_mem
(
    // Clock
    input wire clk,
    // Target port
    input wire [11:0] t_addr,
    input wire t_en,
    input wire t_wr,
    input wire [7:0] t_wdata,
    output reg [8:0] t_rword,
    // Supervisor port
    input wire s_en,
    input wire s_wr,
    input wire [11:0] s_addr,
    input wire [8:0] s_wdata,
    output reg [8:0] s_rword
);
    reg [8:0] mem [0:`EBL_DEPTH-1];

    // One write per cycle: supervisor loads code and flag, else target writes the byte
    // Target writes keep the flag bit so a data store never disarms a breakpoint
    always @(posedge clk)
    begin
        if (s_en && s_wr)
            mem[s_addr] <= s_wdata; // RL7
        else if (t_en && t_wr)
            mem[t_addr] <= {mem[t_addr][8], t_wdata}; // RL1
        t_rword <= mem[t_addr]; // RL1
        s_rword <= mem[s_addr];
    end
endmodule

// ==== sim/ebl_top_monitor.sv ====
// Port checker for the break link block
`timescale 1ns/10ps
`include "ebl_consts.vh"
module ebl_monitor
(
    // Clock and reset
    input wire MCLK,
    input wire RST_B,
    // Bus side
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [31:0] PRDATA,
    // Target side
    input wire T_PFETCH,
    input wire T_DRD,
    input wire T_DWR,
    input wire T_XMOVE,
    input wire T_CYCLE,
    input wire T_INSTR,
    input wire T_STEP_B,
    // Outputs watched
    input wire TRIG_OUT,
    input wire TRACE_REQ,
    input wire IRQ
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    wire strb = T_PFETCH | T_DRD | T_DWR | T_XMOVE | T_CYCLE | T_INSTR;
    wire apbw = PSEL & PENABLE & PWRITE;
    reg [2:0] act_r;
    reg [3:0] hc_r;
    // Recent causes; a halt and each rise of trigger, trace request or interrupt needs one
    always @(posedge MCLK or negedge RST_B)
        if (!RST_B)
            act_r <= 3'h0;
        else
            act_r <= {act_r[1:0], strb | apbw};
    // Length of the current trigger pulse
    always @(posedge MCLK or negedge RST_B)
        if (!RST_B)
            hc_r <= 4'h0;
        else
            hc_r <= TRIG_OUT ? hc_r + 4'h1 : 4'h0;
    AST_STEP_FALL: assert property ($fell(T_STEP_B) |-> |act_r)
        else $error("halt with no access or command");
    AST_STEP_RISE: assert property ($rose(T_STEP_B) |-> $past(apbw) || $past(apbw, 2))
        else $error("run started without a bus write");
    AST_TRIG_LEN: assert property ($fell(TRIG_OUT) |-> hc_r == `EBL_PULSE_CYC)
        else $error("trigger pulse length wrong");
    AST_TRIG_CAUSE: assert property ($rose(TRIG_OUT) |-> |act_r)
        else $error("trigger with no access");
    AST_TRIG_RUN: assert property ($rose(TRIG_OUT) |-> T_STEP_B)
        else $error("trigger while halted");
    AST_TRACE_CAUSE: assert property ($rose(TRACE_REQ) |-> |act_r)
        else $error("trace request with no access");
    AST_TRACE_HALT: assert property ($rose(TRACE_REQ) |-> ##[0:2] !T_STEP_B)
        else $error("trace request without halt");
    AST_IRQ_CAUSE: assert property ($rose(IRQ) |-> |act_r)
        else $error("interrupt with no event");
    AST_PRD_HOLD: assert property ($changed(PRDATA) |-> $past(PSEL & !PWRITE))
        else $error("read data moved outside a read");
    cover property ($fell(T_STEP_B));
    cover property ($rose(TRIG_OUT));
    cover property ($rose(IRQ));
endmodule
bind ebl_top ebl_monitor i_ebl_monitor(.*);

// ==== sim/ebl_tgt_model.sv ====
// Target processor model driving the emulator bus
`timescale 1ns/10ps
module ebl_tgt_model
(
    // Clock
    input wire MCLK,
    // Target bus
    output logic [11:0] T_ADDR,
    output logic [7:0] T_WDATA,
    output logic T_PFETCH,
    output logic T_DRD,
    output logic T_DWR,
    output logic T_XMOVE,
    output logic T_CYCLE,
    output logic T_INSTR,
    input wire [7:0] T_RDATA
);
    // Idle bus from time zero
    initial
    begin
        {T_PFETCH, T_DRD, T_DWR, T_XMOVE, T_CYCLE, T_INSTR} = 6'h00;
        T_ADDR = 12'h000;
        T_WDATA = 8'h00;
    end
    // One machine cycle: 0 fetch, 1 data read, 2 data write
    task acc(input [1:0] k, input [11:0] a, input [7:0] d, output [7:0] r);
        @(posedge MCLK);
        T_ADDR <= a;
        T_WDATA <= d;
        T_PFETCH <= k == 2'h0;
        T_INSTR <= k == 2'h0;
        T_DRD <= k == 2'h1;
        T_DWR <= k == 2'h2;
        T_XMOVE <= k != 2'h0;
        T_CYCLE <= 1'b1;
        @(posedge MCLK);
        {T_PFETCH, T_DRD, T_DWR, T_XMOVE, T_CYCLE, T_INSTR} <= 6'h00;
        // Released bus must not keep its last value
        T_ADDR <= ~a;
        T_WDATA <= ~d;
        #1 r = T_RDATA;
    endtask
endmodule

// ==== sim/ebl_top_tb.sv ====
// Self-checking bench for the break link block
`timescale 1ns/10ps
`include "ebl_consts.vh"
module ebl_top_tb;
    logic MCLK, RST_B, PSEL, PENABLE, PWRITE, tseen;
    logic [11:0] PADDR, a;
    logic [31:0] PWDATA, q;
    logic [7:0] r, d;
    logic [11:0] pa [4];
    logic [7:0] pd [4];
    wire [31:0] PRDATA;
    wire [11:0] T_ADDR;
    wire [7:0] T_WDATA, T_RDATA;
    wire PREADY, PSLVERR, T_PFETCH, T_DRD, T_DWR, T_XMOVE, T_CYCLE, T_INSTR;
    wire T_STEP_B, TRIG_OUT, TRACE_REQ, IRQ;
    int num_errors, checked, i;
    ebl_top i_ebl_top(.*);
    ebl_tgt_model i_ebl_tgt_model(.*);
    // 25 MHz clock
    initial
    begin
        MCLK = 1'b0;
        forever #20 MCLK = ~MCLK;
    end
    // Trigger seen since the last access
    always @(posedge MCLK)
        if (TRIG_OUT)
            tseen <= 1'b1;
    task chk(input [31:0] s, input [31:0] e);
        checked++;
        if (s !== e)
        begin
            num_errors++;
            $display("[FAIL] t=%0t seen %h exp %h", $time, s, e);
        end
    endtask
    // APB transfer; ready wait is bounded
    task apb(input w, input [11:0] ad, input [31:0] wd);
        int n;
        @(posedge MCLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= ad;
        PWDATA <= wd;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        @(posedge MCLK);
        for (n = 0; PREADY !== 1'b1 && n < 20; n++)
            @(posedge MCLK);
        chk(PREADY, 1'b1);
        if (PREADY !== 1'b1)
            test_done;
        q = PRDATA;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        repeat (2) @(posedge MCLK);
        #1;
    endtask
    // Control word: mode low, command bits above
    function [31:0] cw(input [2:0] m, input [5:0] b);
        cw = {23'h0, b, m};
    endfunction
    // Clear status and break, then release
    task run(input [2:0] m, input [5:0] b);
        apb(1, `EBL_OFF_STAT, 32'h1f);
        apb(1, `EBL_OFF_CTRL, cw(m, b | 6'h10));
        apb(1, `EBL_OFF_CTRL, cw(m, b | 6'h08));
    endtask
    // One access, long enough for a trigger pulse to end
    task go(input [1:0] k, input [11:0] ad, input [7:0] wd);
        tseen = 1'b0;
        i_ebl_tgt_model.acc(k, ad, wd, r);
        repeat (8) @(posedge MCLK);
        #1;
    endtask
    task test_done;
        $display("Errors %0d, checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        {RST_B, PSEL, PENABLE, PWRITE, tseen} = 5'h00;
        PADDR = 12'h000;
        PWDATA = 32'h0;
        q = $urandom(36);
        repeat (20) @(posedge MCLK);
        chk(T_STEP_B, 1'b0);
        RST_B <= 1'b1;
        // Several flags armed at once, nine bits read back
        for (i = 0; i < 4; i++)
        begin
            pa[i] = {i[1:0], 10'($urandom)};
            pd[i] = $urandom;
            apb(1, `EBL_OFF_BPAD, pa[i]);
            apb(1, `EBL_OFF_BPDT, {i[0], pd[i]});
            apb(0, `EBL_OFF_BPDT, 0);
            chk(q, {i[0], pd[i]});
        end
        // Free run never halts; flags pulse the trigger
        run(`EBL_MODE_FREE, 6'h00);
        for (i = 0; i < 4; i++)
        begin
            go(0, pa[i], 8'h00);
            chk(r, pd[i]);
            chk({tseen, T_STEP_B}, {i[0], 1'b1});
        end
        // Break mode halts on the flag only
        run(`EBL_MODE_BREAK, 6'h00);
        go(0, pa[0], 8'h00);
        chk(T_STEP_B, 1'b1);
        go(0, pa[1], 8'h00);
        chk({tseen, T_STEP_B}, 2'b00);
        apb(0, `EBL_OFF_STAT, 0);
        chk(q[4], 1'b1);
        apb(1, `EBL_OFF_CTRL, cw(`EBL_MODE_BREAK, 6'h08));
        chk(T_STEP_B, 1'b0);
        // Interrupt masked, unmasked, cleared
        apb(1, `EBL_OFF_IMSK, 0);
        chk(IRQ, 1'b0);
        apb(1, `EBL_OFF_IMSK, 32'h0f);
        chk(IRQ, 1'b1);
        apb(1, `EBL_OFF_STAT, 32'h0f);
        apb(0, `EBL_OFF_STAT, 0);
        chk({q[3:0], IRQ}, 5'h00);
        // Flag on a data word
        a = $urandom;
        d = $urandom;
        apb(1, `EBL_OFF_CTRL, cw(`EBL_MODE_BREAK, 6'h30));
        apb(1, `EBL_OFF_BPAD, a);
        apb(1, `EBL_OFF_BPDT, {1'b1, d});
        run(`EBL_MODE_BREAK, 6'h20);
        go(1, a, 8'h00);
        chk({r, T_STEP_B}, {d, 1'b0});
        run(`EBL_MODE_STEP, 6'h00);
        go(0, pa[0], 8'h00);
        chk(T_STEP_B, 1'b0);
        run(`EBL_MODE_TFLAG, 6'h00);
        go(0, pa[0], 8'h00);
        chk({TRACE_REQ, T_STEP_B}, 2'b01);
        go(0, pa[1], 8'h00);
        chk({TRACE_REQ, tseen}, 2'b10);
        run(`EBL_MODE_TRACE, 6'h00);
        go(0, pa[2], 8'h00);
        chk(TRACE_REQ, 1'b1);
        apb(0, `EBL_OFF_TRPC, 0);
        chk(q[11:0], pa[2]);
        run(`EBL_MODE_FREE, 6'h00);
        apb(1, `EBL_OFF_CTRL, cw(`EBL_MODE_FREE, 6'h04));
        chk(T_STEP_B, 1'b0);
        // Mailbox over program space answers any address
        d = $urandom;
        apb(1, `EBL_OFF_MBOX, d);
        run(`EBL_MODE_STEP, 6'h01);
        go(0, 12'($urandom), 8'h00);
        chk(r, d);
        // Data move into the mailbox halts the target
        run(`EBL_MODE_XMOVE, 6'h02);
        d = $urandom;
        go(2, 12'($urandom), d);
        chk(T_STEP_B, 1'b0);
        apb(0, `EBL_OFF_MBOX, 0);
        chk(q[7:0], d);
        test_done;
    end
endmodule
